// ---- src/fpl_pkg.sv ----
/*
 fast_parallel_load configuration port: constants and state encoding.
 assumes a 50 mhz system clock; all pins arrive unsynchronised.
*/
package fpl_pkg;
  localparam int CLK_MHZ = 50;
  localparam int REQ_FALL_NS = 600;
  localparam int REQ_FALL_CYC = REQ_FALL_NS * CLK_MHZ / 1000;
  localparam int STATUS_MIN_US = 268;
  localparam int STATUS_MIN_CYC = STATUS_MIN_US * CLK_MHZ;
  localparam int INIT_MIN_US = 175;
  localparam int INIT_MAX_US = 437;
  localparam int INIT_CYC = (INIT_MIN_US + INIT_MAX_US) / 2 * CLK_MHZ;
  localparam int USR_CLK_EDGES = 8576;
  localparam int USR_ENABLE_LOADS = 4;
  localparam int FALL_EDGES_AFTER_DONE = 2;
  localparam int CNT_W = 20;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  typedef enum logic [5:0] {
    FPL_POR = 6'b00_0001,
    FPL_RESET = 6'b00_0010,
    FPL_LOAD = 6'b00_0100,
    FPL_EDGES = 6'b00_1000,
    FPL_INIT = 6'b01_0000,
    FPL_USER = 6'b10_0000
  } fpl_state_e;
endpackage

// ---- src/fpl_sync.sv ----
/*
 two flip-flop synchroniser for a bundle of pin inputs.
 assumes inputs are asynchronous to clk.
*/
`timescale 1ns/10ps
module fpl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb
  begin
    next_meta = d;
    next_q = meta;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// ---- src/fpl_port.sv ----
/*
 fast_parallel_load configuration port, device side.
 assumes the host obeys the load clock timing; the stream length, the
 clock-per-word ratio and option bits come from the device's own control.
*/
`timescale 1ns/10ps
module fpl_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic config_req_n,
  input wire logic load_clock,
  input wire logic [fpl_pkg::WORD_W-1:0] load_data,
  input wire logic [1:0] bus_width,
  input wire logic [3:0] words_ratio,
  input wire logic [fpl_pkg::CNT_W-1:0] stream_words,
  input wire logic stream_error,
  input wire logic init_done_opt,
  input wire logic user_init_opt,
  input wire logic user_init_clock,
  output logic status_n,
  output logic load_done,
  output logic init_done_n,
  output logic init_done_oe,
  output logic user_mode,
  output logic user_clk_enabled,
  output logic word_valid,
  output logic [fpl_pkg::WORD_W-1:0] word_data
);
  import fpl_pkg::*;

  logic [fpl_pkg::WORD_W+2:0] pins_raw;
  logic [fpl_pkg::WORD_W+2:0] pins;
  logic req_n_s;
  logic lclk_s;
  logic uclk_s;
  logic [WORD_W-1:0] data_s;

  assign pins_raw = {user_init_clock, config_req_n, load_clock, load_data};
  fpl_sync #(.W(WORD_W + 3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins)
  );
  assign uclk_s = pins[WORD_W+2];
  assign req_n_s = pins[WORD_W+1];
  assign lclk_s = pins[WORD_W];
  assign data_s = pins[WORD_W-1:0];

  fpl_state_e state, next_state;
  logic [CNT_W-1:0] timer, next_timer;
  logic [CNT_W-1:0] words, next_words;
  logic [3:0] phase, next_phase;
  logic lclk_d, next_lclk_d;
  logic uclk_d, next_uclk_d;
  logic opt_seen, next_opt_seen;
  logic next_status_n, next_load_done, next_user_mode, next_uen;
  logic next_word_valid;
  logic [WORD_W-1:0] next_word_data;
  logic rise, fall, urise;
  logic [3:0] ratio;
  logic [CNT_W-1:0] lcount, next_lcount;
  logic [CNT_W-1:0] lperiod, next_lperiod;
  logic uen_due;

  assign rise = lclk_s & ~lclk_d;
  assign fall = ~lclk_s & lclk_d;
  assign urise = uclk_s & ~uclk_d;
  assign ratio = (words_ratio == 4'h0) ? 4'h1 : words_ratio;
  // user clock waits four of the longest load periods seen in the load, counted from done
  assign uen_due = user_init_opt &&
    ((&lcount) || 32'(lcount) >= 32'(lperiod) * 32'(USR_ENABLE_LOADS));

  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_words = words;
    next_phase = phase;
    next_lclk_d = lclk_s;
    next_uclk_d = uclk_s;
    next_opt_seen = opt_seen;
    next_status_n = status_n;
    next_load_done = load_done;
    next_user_mode = user_mode;
    next_uen = user_clk_enabled;
    next_word_valid = 1'b0;
    next_word_data = word_data;
    next_lcount = (&lcount) ? lcount : lcount + 1'b1;
    next_lperiod = lperiod;
    case (state)
      FPL_POR:
      begin
        next_status_n = 1'b0;
        next_load_done = 1'b0;
        next_timer = timer + 1'b1;
        if (timer >= CNT_W'(STATUS_MIN_CYC))
        begin
          next_state = FPL_RESET;
          next_timer = timer;
        end
      end
      FPL_RESET:
      begin
        next_status_n = 1'b0;
        next_load_done = 1'b0;
        next_user_mode = 1'b0;
        next_uen = 1'b0;
        next_opt_seen = 1'b0;
        next_words = '0;
        next_phase = '0;
        next_lcount = '0;
        next_lperiod = '0;
        if (timer < CNT_W'(STATUS_MIN_CYC))
          next_timer = timer + 1'b1;
        else if (req_n_s)
        begin
          next_status_n = 1'b1;
          next_state = FPL_LOAD;
          next_timer = '0;
        end
      end
      FPL_LOAD:
      begin
        if (stream_error)
        begin
          next_status_n = 1'b0;
          next_state = FPL_RESET;
          next_timer = '0;
        end
        else if (rise)
        begin
          next_lcount = '0;
          // first rise only opens the period measurement
          if ((words != '0 || phase != 4'h0) && lcount >= lperiod)
            next_lperiod = (&lcount) ? lcount : lcount + 1'b1;
          if (phase == 4'h0)
          begin
            next_word_valid = 1'b1;
            case (bus_width)
              WIDTH_8: next_word_data = {{(WORD_W-BYTE_W){1'b0}},
                data_s[BYTE_W-1:0]};
              WIDTH_16: next_word_data = {{(WORD_W-HALF_W){1'b0}},
                data_s[HALF_W-1:0]};
              default: next_word_data = data_s;
            endcase
            if (init_done_opt)
              next_opt_seen = 1'b1;
            next_words = words + 1'b1;
          end
          // a word is taken on its first clock; the stream end is checked only on its last clock of the ratio
          if (phase + 4'h1 >= ratio)
          begin
            next_phase = 4'h0;
            if (next_words >= stream_words)
            begin
              next_load_done = 1'b1;
              next_state = FPL_EDGES;
              next_timer = '0;
            end
          end
          else
            next_phase = phase + 4'h1;
        end
      end
      FPL_EDGES:
      begin
        if (uen_due)
          next_uen = 1'b1;
        if (fall)
        begin
          next_timer = timer + 1'b1;
          if (timer + 1'b1 >= CNT_W'(FALL_EDGES_AFTER_DONE))
          begin
            next_state = FPL_INIT;
            next_timer = '0;
          end
        end
      end
      FPL_INIT:
      begin
        if (uen_due)
          next_uen = 1'b1;
        if (!user_init_opt)
          next_timer = timer + 1'b1;
        else if (user_clk_enabled && urise)
          next_timer = timer + 1'b1;
        if ((!user_init_opt && timer >= CNT_W'(INIT_CYC)) ||
          (user_init_opt && timer >= CNT_W'(USR_CLK_EDGES)))
        begin
          next_user_mode = 1'b1;
          next_state = FPL_USER;
        end
      end
      FPL_USER:
      begin
        next_status_n = 1'b1;
        next_load_done = 1'b1;
      end
      default: next_state = FPL_POR;
    endcase
    if (!req_n_s && state != FPL_POR)
    begin
      next_state = FPL_RESET;
      next_status_n = 1'b0;
      next_load_done = 1'b0;
      next_user_mode = 1'b0;
      next_uen = 1'b0;
      next_timer = (state == FPL_RESET) ? next_timer : '0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= FPL_POR;
      timer <= '0;
      words <= '0;
      phase <= '0;
      lclk_d <= 1'b0;
      uclk_d <= 1'b0;
      opt_seen <= 1'b0;
      status_n <= 1'b0;
      load_done <= 1'b0;
      user_mode <= 1'b0;
      user_clk_enabled <= 1'b0;
      word_valid <= 1'b0;
      word_data <= '0;
      lcount <= '0;
      lperiod <= '0;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      words <= next_words;
      phase <= next_phase;
      lclk_d <= next_lclk_d;
      uclk_d <= next_uclk_d;
      opt_seen <= next_opt_seen;
      status_n <= next_status_n;
      load_done <= next_load_done;
      user_mode <= next_user_mode;
      user_clk_enabled <= next_uen;
      word_valid <= next_word_valid;
      word_data <= next_word_data;
      lcount <= next_lcount;
      lperiod <= next_lperiod;
    end
  end

  assign init_done_n = 1'b0;
  assign init_done_oe = opt_seen & ~user_mode;
endmodule

// ---- sim/fpl_port_chk.sv ----
/*
 checker for the fpl_port pins, bound to every instance.
 assumes the fixed counts of fpl_pkg and a 50 mhz clk.
*/
`timescale 1ns/10ps
module fpl_port_chk
  import fpl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic config_req_n,
  input wire logic [1:0] bus_width,
  input wire logic [fpl_pkg::CNT_W-1:0] stream_words,
  input wire logic init_done_opt,
  input wire logic status_n,
  input wire logic load_done,
  input wire logic init_done_n,
  input wire logic init_done_oe,
  input wire logic user_mode,
  input wire logic user_clk_enabled,
  input wire logic word_valid,
  input wire logic [fpl_pkg::WORD_W-1:0] word_data
);
  localparam int FALL_MAX = REQ_FALL_CYC;
  logic [13:0] age;
  logic [13:0] next_age;
  logic [CNT_W-1:0] seen;
  logic [CNT_W-1:0] next_seen;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  always_comb
  begin
    next_age = (age == 14'h3fff) ? age : age + 14'h0001;
    next_seen = status_n ? seen + CNT_W'(word_valid) : '0;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      age <= 14'h0000;
      seen <= '0;
    end
    else
    begin
      age <= next_age;
      seen <= next_seen;
    end
  end
  sequence s_cleared;
    !status_n && !load_done;
  endsequence
  a_req_clears_flags:
    assert property ($fell(config_req_n) |-> ##[1:FALL_MAX] s_cleared)
    else $error("flags not cleared after request");
  a_user_flags_high:
    assert property (user_mode && config_req_n |-> status_n && load_done)
    else $error("flags low in user mode");
  a_por_status_low:
    assert property (age < STATUS_MIN_CYC |-> !status_n)
    else $error("status released early");
  a_status_blocks_done:
    assert property (!status_n |-> !load_done)
    else $error("load done while status low");
  a_user_no_words:
    assert property (user_mode |-> !word_valid)
    else $error("word taken in user mode");
  a_narrow_upper_zero:
    assert property (word_valid |-> (bus_width == WIDTH_32 ||
      word_data[31:16] == 16'h0000) && (bus_width != WIDTH_8 ||
      word_data[15:8] == 8'h00))
    else $error("narrow word has upper bits");
  a_done_with_word:
    assert property ($rose(load_done) |->
      seen + CNT_W'(word_valid) == stream_words)
    else $error("load done before whole stream");
  a_init_drives_low:
    assert property (init_done_oe |-> !init_done_n && !user_mode)
    else $error("init done not driven low");
  a_init_opt_drive:
    assert property (word_valid && init_done_opt |->
      init_done_oe && !init_done_n)
    else $error("init done not driven after option");
  a_clk_en_done:
    assert property ($rose(user_clk_enabled) |-> load_done)
    else $error("user clock enabled before done");
  a_word_single:
    assert property (word_valid |=> !word_valid)
    else $error("word pulse too long");
endmodule
bind fpl_port fpl_port_chk chk (
  .clk(clk),
  .resetn(resetn),
  .config_req_n(config_req_n),
  .bus_width(bus_width),
  .stream_words(stream_words),
  .init_done_opt(init_done_opt),
  .status_n(status_n),
  .load_done(load_done),
  .init_done_n(init_done_n),
  .init_done_oe(init_done_oe),
  .user_mode(user_mode),
  .user_clk_enabled(user_clk_enabled),
  .word_valid(word_valid),
  .word_data(word_data)
);

// ---- sim/fpl_host.sv ----
/*
 host model: request pulse, load clock and data words.
 assumes clk is the bench clock; load clock stands low when idle.
*/
`timescale 1ns/10ps
module fpl_host (
  input wire logic clk,
  output logic config_req_n,
  output logic load_clock,
  output logic [31:0] load_data
);
  initial
  begin
    config_req_n = 1'b1;
    load_clock = 1'b0;
    load_data = 32'h0000_0000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic request();
    config_req_n = 1'b0;
    tick(100);
    config_req_n = 1'b1;
  endtask
  task automatic edges(input int n);
    repeat (n)
    begin
      load_clock = 1'b1;
      tick(4);
      load_clock = 1'b0;
      tick(4);
    end
  endtask
  task automatic word(input logic [31:0] w, input int n);
    load_data = w;
    tick(1);
    edges(n);
    load_data = ~w;
    tick(1);
  endtask
endmodule

// ---- sim/fpl_port_test.sv ----
/*
 bench for fpl_port: three loads over widths, ratios and options.
 assumes fpl_host on the host pins and the unshortened counts.
*/
`timescale 1ns/10ps
module fpl_port_test;
  import fpl_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic user_init_clock = 1'b0;
  logic [1:0] bus_width = WIDTH_8;
  logic [3:0] words_ratio = 4'h1;
  logic init_done_opt = 1'b0;
  logic user_init_opt = 1'b0;
  logic [CNT_W-1:0] stream_words = 20'h0_0002;
  logic stream_error = 1'b0;
  logic config_req_n, load_clock, status_n, load_done, init_done_n;
  logic init_done_oe, user_mode, user_clk_enabled, word_valid;
  logic [31:0] load_data, word_data, got;
  int fail_count = 0;
  int check_count = 0;
  int nw = 0;
  int n, n0;
  logic [31:0] mk [3] = '{32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff};
  logic [1:0] wd [3] = '{WIDTH_8, WIDTH_16, WIDTH_32};
  logic [31:0] pat [2] = '{32'h5a3c_96e1, 32'h81c3_7e18};
  always #10 clk = ~clk;
  always #25 user_init_clock = ~user_init_clock;
  fpl_host h (
    .clk(clk),
    .config_req_n(config_req_n),
    .load_clock(load_clock),
    .load_data(load_data)
  );
  fpl_port uut (
    .clk(clk),
    .resetn(resetn),
    .config_req_n(config_req_n),
    .load_clock(load_clock),
    .load_data(load_data),
    .bus_width(bus_width),
    .words_ratio(words_ratio),
    .stream_words(stream_words),
    .stream_error(stream_error),
    .init_done_opt(init_done_opt),
    .user_init_opt(user_init_opt),
    .user_init_clock(user_init_clock),
    .status_n(status_n),
    .load_done(load_done),
    .init_done_n(init_done_n),
    .init_done_oe(init_done_oe),
    .user_mode(user_mode),
    .user_clk_enabled(user_clk_enabled),
    .word_valid(word_valid),
    .word_data(word_data)
  );
  always @(posedge clk)
    if (word_valid === 1'b1)
    begin
      got <= word_data;
      nw <= nw + 1;
    end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic wait_hi(input int k, input int lim, output int c);
    c = 0;
    while ((k ? user_mode : status_n) !== 1'b1)
    begin
      @(posedge clk);
      c++;
      if (c > lim)
      begin
        fail_count++;
        final_report();
      end
    end
    #1;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      bus_width = wd[i];
      words_ratio = 4'(i + 1);
      init_done_opt = (i == 1);
      user_init_opt = (i == 2);
      if (i > 0)
      begin
        h.request();
        chk(load_done, 0);
        chk(status_n, 0);
      end
      wait_hi(0, 80000, n);
      chk(n + (i > 0 ? 100 : 0) >= 13390, 1);
      chk(n <= 75300, 1);
      h.tick(100);
      n0 = nw;
      for (int j = 0; j < 2; j++)
      begin
        h.word(pat[j], i + 1);
        chk(got, pat[j] & mk[i]);
        chk(load_done, j);
      end
      chk(nw - n0, 2);
      chk(init_done_oe, i == 1);
      h.edges(2);
      chk(user_clk_enabled, 0);
      wait_hi(1, 30000, n);
      chk(n >= (i == 2 ? 21000 : 8700), 1);
      chk(n <= (i == 2 ? 29850 : 21850), 1);
      chk(user_clk_enabled, i == 2);
      chk(status_n && load_done, 1);
      h.edges(1);
      chk(nw - n0, 2);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule
